//--- bench/aalo_top_tb.sv
`timescale 1ns/100ps
module aalo_top_tb;
	import aalo_pkg::*;
	logic              sys_clk_i = 1'b0;
	logic              rst_b_i = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata;
	logic [STRB_W-1:0] wstrb = '0;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic              arvalid = 1'b0, rready = 1'b0;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp, last_resp;
	logic [7:0]        wreg_o, wreg_at_b;
	aalo_flags_s       flags_o;
	logic [DATA_W-1:0] got;
	int                n_fail = 0;
	int                checks = 0;

	always #4 sys_clk_i = ~sys_clk_i;

	aalo_top aalo_top_inst (
		.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .working_register_o(wreg_o),
		.flags_o(flags_o)
	);

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d,
			logic [STRB_W-1:0] s = 4'hF);
		int n;
		@(posedge sys_clk_i);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk_i);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				last_resp = bresp;
				wreg_at_b = wreg_o;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 50) begin
			n_fail++;
			close_out();
		end
	endtask

	task automatic rd(logic [ADDR_W-1:0] a);
		int n;
		@(posedge sys_clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk_i);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				got = rdata;
				last_resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 50) begin
			n_fail++;
			close_out();
		end
	endtask

	task automatic rd_chk(string what, logic [ADDR_W-1:0] a,
			logic [31:0] exp);
		rd(a);
		chk(what, exp, got);
	endtask

	// Result must already stand at the first response edge
	task automatic exec(logic [1:0] op, logic dest, logic [5:0] fa,
			logic [7:0] imm, logic [7:0] exp_w, logic [2:0] exp_f);
		logic [DATA_W-1:0] c;
		c = (32'(op) << CMD_OP_LSB) | (32'(dest) << CMD_DEST_BIT)
			| (32'(fa) << CMD_ADDR_LSB) | 32'(imm);
		wr(OFS_CMD, c);
		chk("bresp", 32'(RESP_OKAY), 32'(last_resp));
		chk("wreg", 32'(exp_w), 32'(wreg_at_b));
		chk("flags", 32'(exp_f), 32'(flags_o));
	endtask

	function automatic logic [ADDR_W-1:0] fofs(int n);
		return OFS_FILE_BASE + ADDR_W'(4 * n);
	endfunction

	initial begin
		repeat (4) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		rd_chk("wreg rst", OFS_WREG, 32'h0000_0000);
		rd_chk("flags rst", OFS_FLAGS, 32'h0000_0000);
		rd_chk("file63 rst", fofs(63), 32'h0000_0000);
		$display("test reset done");

		wr(OFS_WREG, 32'h0000_000F);
		exec(2'h1, 1'b0, 6'h00, 8'h01, 8'h10, 3'h2);
		exec(2'h1, 1'b0, 6'h00, 8'hF0, 8'h00, 3'h5);
		exec(2'h1, 1'b0, 6'h00, 8'hFF, 8'hFF, 3'h0);
		exec(2'h1, 1'b0, 6'h00, 8'h01, 8'h00, 3'h7);
		rd_chk("wreg add", OFS_WREG, 32'h0000_0000);
		exec(2'h0, 1'b0, 6'h00, 8'h55, 8'h00, 3'h7);
		$display("test add done");

		wr(fofs(63), 32'h0000_003C);
		wr(OFS_WREG, 32'h0000_00F0);
		wr(OFS_FLAGS, 32'h0000_0006);
		exec(2'h2, 1'b0, 6'h3F, 8'h00, 8'h30, 3'h6);
		rd_chk("file63", fofs(63), 32'h0000_003C);
		wr(fofs(0), 32'h0000_00F0);
		wr(OFS_WREG, 32'h0000_000F);
		exec(2'h2, 1'b1, 6'h00, 8'h00, 8'h0F, 3'h7);
		rd_chk("file0", fofs(0), 32'h0000_0000);
		wr(fofs(63), 32'h0000_00C3);
		wr(OFS_WREG, 32'h0000_0081);
		wr(OFS_FLAGS, 32'h0000_0000);
		exec(2'h2, 1'b1, 6'h3F, 8'h00, 8'h81, 3'h0);
		rd_chk("file63 d1", fofs(63), 32'h0000_0081);
		$display("test and file done");

		wr(OFS_WREG, 32'h0000_00AA);
		wr(OFS_FLAGS, 32'h0000_0006);
		exec(2'h3, 1'b0, 6'h00, 8'h55, 8'h00, 3'h7);
		wr(OFS_WREG, 32'h0000_00FF);
		wr(OFS_FLAGS, 32'h0000_0006);
		exec(2'h3, 1'b0, 6'h00, 8'h81, 8'h81, 3'h6);
		rd_chk("flags andi", OFS_FLAGS, 32'h0000_0006);
		rd_chk("cmd readback", OFS_CMD, 32'h0003_0081);
		$display("test and imm done");

		// Byte 0 strobe off leaves the 8-bit register alone
		wr(OFS_WREG, 32'h0000_0055, 4'hE);
		chk("bresp strb", 32'(RESP_OKAY), 32'(last_resp));
		rd_chk("wreg strb", OFS_WREG, 32'h0000_0081);
		$display("test strobe done");

		wr(12'h00C, 32'h0000_0012);
		chk("bresp unm", 32'(RESP_SLVERR), 32'(last_resp));
		rd_chk("rdata unm", 12'h00C, 32'h0000_0000);
		chk("rresp unm", 32'(RESP_SLVERR), 32'(last_resp));
		rd_chk("wreg unm", OFS_WREG, 32'h0000_0081);
		$display("test unmapped done");
		close_out();
	end
endmodule // aalo_top_tb

//--- rtl/aalo_alu.sv
`timescale 1ns/100ps
module aalo_alu (
	// Operation
	input  aalo_pkg::aalo_op_e    op_i,
	input  logic                  dest_i,
	input  logic [7:0]            imm_i,
	// Operands
	input  logic [7:0]            wreg_i,
	input  logic [7:0]            file_i,
	input  aalo_pkg::aalo_flags_s flags_i,
	// Results
	output logic [7:0]            result_o,
	output aalo_pkg::aalo_flags_s flags_o,
	output logic                  wreg_we_o,
	output logic                  file_we_o
);
	import aalo_pkg::*;

	logic [8:0] sum9;
	logic [4:0] sum4;
	logic [7:0] and_file;
	logic [7:0] and_imm;

	assign sum9     = {1'b0, wreg_i} + {1'b0, imm_i};
	assign sum4     = {1'b0, wreg_i[3:0]} + {1'b0, imm_i[3:0]};
	assign and_file = wreg_i & file_i;
	assign and_imm  = wreg_i & imm_i;

	always_comb begin
		result_o  = wreg_i;
		flags_o   = flags_i;
		wreg_we_o = 1'b0;
		file_we_o = 1'b0;
		case (op_i)
			OP_ADD_IMM: begin
				result_o           = sum9[7:0];
				flags_o.carry      = sum9[8];
				flags_o.half_carry = sum4[4];
				flags_o.zero       = (sum9[7:0] == 8'h00);
				wreg_we_o          = 1'b1;
			end
			OP_AND_FILE: begin
				result_o     = and_file;
				// Carry and half carry pass through untouched
				flags_o.zero = (and_file == 8'h00);
				wreg_we_o    = ~dest_i;
				file_we_o    = dest_i;
			end
			OP_AND_IMM: begin
				result_o     = and_imm;
				flags_o.zero = (and_imm == 8'h00);
				wreg_we_o    = 1'b1;
			end
			default: begin
				result_o = wreg_i;
			end
		endcase
	end

endmodule // aalo_alu

//--- rtl/aalo_pkg.sv
package aalo_pkg;

	// Bus geometry
	localparam int unsigned ADDR_W     = 12;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned STRB_W     = DATA_W / 8;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CMD       = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_WREG      = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_FLAGS     = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_FILE_BASE = 12'h100;

	// File register bank: locations 0 to 63
	localparam int unsigned FILE_DEPTH = 64;
	localparam int unsigned FILE_IDX_W = 6;
	localparam int unsigned FILE_IDX_LSB = 2;

	// Command word field positions
	localparam int unsigned CMD_IMM_LSB  = 0;
	localparam int unsigned CMD_ADDR_LSB = 8;
	localparam int unsigned CMD_DEST_BIT = 14;
	localparam int unsigned CMD_OP_LSB   = 16;

	// Flag register bit positions
	localparam int unsigned FLAG_ZERO_BIT  = 0;
	localparam int unsigned FLAG_HALF_BIT  = 1;
	localparam int unsigned FLAG_CARRY_BIT = 2;

	// Values after reset
	localparam logic [7:0]        WREG_RST  = 8'h00;
	localparam logic [7:0]        FILE_RST  = 8'h00;
	localparam logic [DATA_W-1:0] CMD_RST   = 32'h0000_0000;
	localparam logic [2:0]        FLAGS_RST = 3'h0;

	// Response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Cycles from command acceptance to result write
	localparam int unsigned EXEC_CYCLES = 1;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_ADD_IMM,
		OP_AND_FILE,
		OP_AND_IMM
	} aalo_op_e;

	typedef struct packed {
		logic [13:0] rsvd;
		aalo_op_e    op;
		logic        pad;
		logic        dest;
		logic [5:0]  file_addr;
		logic [7:0]  imm;
	} aalo_cmd_s;

	typedef struct packed {
		logic carry;
		logic half_carry;
		logic zero;
	} aalo_flags_s;

endpackage

//--- rtl/aalo_top.sv
// Contract
// - Add immediate adds into working register.
// - Add immediate updates carry, half carry, zero.
// - And with file, destination zero: working register.
// - Destination one writes the file register.
// - File address covers locations 0 to 63.
// - And with file changes zero only.
// - And immediate writes working register.
// - And immediate changes zero only.
// - Every operation completes in one cycle.
`timescale 1ns/100ps
module aalo_top (
	// Clock and reset
	input  logic                        sys_clk_i,
	input  logic                        rst_b_i,
	// Write address channel
	input  logic [aalo_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input  logic                        s_axi_awvalid_i,
	output logic                        s_axi_awready_o,
	// Write data channel
	input  logic [aalo_pkg::DATA_W-1:0] s_axi_wdata_i,
	input  logic [aalo_pkg::STRB_W-1:0] s_axi_wstrb_i,
	input  logic                        s_axi_wvalid_i,
	output logic                        s_axi_wready_o,
	// Write response channel
	output logic [1:0]                  s_axi_bresp_o,
	output logic                        s_axi_bvalid_o,
	input  logic                        s_axi_bready_i,
	// Read address channel
	input  logic [aalo_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input  logic                        s_axi_arvalid_i,
	output logic                        s_axi_arready_o,
	// Read data channel
	output logic [aalo_pkg::DATA_W-1:0] s_axi_rdata_o,
	output logic [1:0]                  s_axi_rresp_o,
	output logic                        s_axi_rvalid_o,
	input  logic                        s_axi_rready_i,
	// Datapath state
	output logic [7:0]                  working_register_o,
	output aalo_pkg::aalo_flags_s       flags_o
);
	import aalo_pkg::*;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs);
		reg_hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
	endfunction

	function automatic logic file_hit(input logic [ADDR_W-1:0] a);
		file_hit = (a[ADDR_W-1:8] == OFS_FILE_BASE[ADDR_W-1:8]);
	endfunction

	function automatic logic [DATA_W-1:0] strb_merge(
		input logic [DATA_W-1:0] old_w,
		input logic [DATA_W-1:0] new_w,
		input logic [STRB_W-1:0] strb);
		logic [DATA_W-1:0] r;
		r = old_w;
		for (int b = 0; b < STRB_W; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = new_w[8*b +: 8];
			end
		end
		strb_merge = r;
	endfunction

	// Register state
	aalo_cmd_s         cmd_q;
	logic [7:0]        wreg;
	aalo_flags_s       flags;
	logic [7:0]        file_q [FILE_DEPTH];

	// Write path holding state
	logic              aw_full;
	logic              w_full;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [DATA_W-1:0] w_data_q;
	logic [STRB_W-1:0] w_strb_q;

	// Write decode
	logic              do_write;
	logic              wr_cmd;
	logic              wr_wreg;
	logic              wr_flags;
	logic              wr_file;
	logic              wr_known;
	logic [FILE_IDX_W-1:0] wr_idx;
	logic              launch;
	aalo_cmd_s         next_cmd;

	assign do_write = aw_full & w_full;
	assign wr_cmd   = reg_hit(aw_addr_q, OFS_CMD);
	assign wr_wreg  = reg_hit(aw_addr_q, OFS_WREG);
	assign wr_flags = reg_hit(aw_addr_q, OFS_FLAGS);
	assign wr_file  = file_hit(aw_addr_q);
	assign wr_known = wr_cmd | wr_wreg | wr_flags | wr_file;
	assign wr_idx   = aw_addr_q[FILE_IDX_LSB +: FILE_IDX_W];
	assign next_cmd = aalo_cmd_s'(strb_merge(cmd_q, w_data_q, w_strb_q));
	// Writing the command word executes it in the same edge
	assign launch   = do_write & wr_cmd;

	// Datapath
	logic [7:0]        file_rd;
	logic [7:0]        alu_result;
	aalo_flags_s       alu_flags;
	logic              alu_wreg_we;
	logic              alu_file_we;

	assign file_rd = file_q[next_cmd.file_addr];

	aalo_alu aalo_alu_inst (
		.op_i      (launch ? next_cmd.op : OP_NONE),
		.dest_i    (next_cmd.dest),
		.imm_i     (next_cmd.imm),
		.wreg_i    (wreg),
		.file_i    (file_rd),
		.flags_i   (flags),
		.result_o  (alu_result),
		.flags_o   (alu_flags),
		.wreg_we_o (alu_wreg_we),
		.file_we_o (alu_file_we)
	);

	// Next values of the software visible state
	logic              sw_byte0;
	logic [7:0]        next_wreg;
	aalo_flags_s       next_flags;

	assign sw_byte0   = do_write & w_strb_q[0];
	assign next_wreg  = alu_wreg_we ? alu_result :
		(sw_byte0 & wr_wreg) ? w_data_q[7:0] : wreg;
	assign next_flags = launch ? alu_flags :
		(sw_byte0 & wr_flags) ? aalo_flags_s'(w_data_q[2:0]) : flags;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			cmd_q <= aalo_cmd_s'(CMD_RST);
			wreg  <= WREG_RST;
			flags <= aalo_flags_s'(FLAGS_RST);
		end else begin
			if (launch) begin
				cmd_q <= next_cmd;
			end
			wreg  <= next_wreg;
			flags <= next_flags;
		end
	end

	// File bank, one byte per word
	genvar gi;
	generate
		for (gi = 0; gi < FILE_DEPTH; gi++) begin : g_file
			logic sw_we;
			logic alu_we;
			assign sw_we  = sw_byte0 & wr_file &
				(wr_idx == FILE_IDX_W'(gi));
			assign alu_we = alu_file_we &
				(next_cmd.file_addr == FILE_IDX_W'(gi));
			always_ff @(posedge sys_clk_i) begin
				if (!rst_b_i) begin
					file_q[gi] <= FILE_RST;
				end else if (alu_we) begin
					file_q[gi] <= alu_result;
				end else if (sw_we) begin
					file_q[gi] <= w_data_q[7:0];
				end
			end
		end
	endgenerate

	// Write channel handling: address and data in either order
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= RESP_OKAY;
			aw_full         <= 1'b0;
			w_full          <= 1'b0;
			aw_addr_q       <= '0;
			w_data_q        <= '0;
			w_strb_q        <= '0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_full         <= 1'b1;
				aw_addr_q       <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_full         <= 1'b1;
				w_data_q       <= s_axi_wdata_i;
				w_strb_q       <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (do_write) begin
				aw_full        <= 1'b0;
				w_full         <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end
			// Channels reopen only after the response is taken
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o  <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	// Read decode
	logic              rd_cmd;
	logic              rd_wreg;
	logic              rd_flags;
	logic              rd_file;
	logic [DATA_W-1:0] rd_word;

	assign rd_cmd   = reg_hit(s_axi_araddr_i, OFS_CMD);
	assign rd_wreg  = reg_hit(s_axi_araddr_i, OFS_WREG);
	assign rd_flags = reg_hit(s_axi_araddr_i, OFS_FLAGS);
	assign rd_file  = file_hit(s_axi_araddr_i);
	assign rd_word  = rd_cmd   ? DATA_W'(cmd_q) :
		rd_wreg  ? {24'h000000, wreg} :
		rd_flags ? {29'h00000000, flags} :
		rd_file  ? {24'h000000,
			file_q[s_axi_araddr_i[FILE_IDX_LSB +: FILE_IDX_W]]} :
		32'h0000_0000;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= '0;
			s_axi_rresp_o   <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= rd_word;
			s_axi_rresp_o   <= (rd_cmd | rd_wreg | rd_flags | rd_file) ?
				RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	assign working_register_o = wreg;
	assign flags_o            = flags;

	// Checking helpers, read only by the properties below
	logic       go_add;
	logic       go_andf;
	logic       go_andi;
	logic [8:0] chk_sum9;
	logic       chk_half;

	assign go_add   = launch & (next_cmd.op == OP_ADD_IMM);
	assign go_andf  = launch & (next_cmd.op == OP_AND_FILE);
	assign go_andi  = launch & (next_cmd.op == OP_AND_IMM);
	assign chk_sum9 = {1'b0, wreg} + {1'b0, next_cmd.imm};
	assign chk_half = ({1'b0, wreg[3:0]} + {1'b0, next_cmd.imm[3:0]}) > 5'h0F;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);

	add_result_a: assert property (
		go_add |=> wreg == $past(chk_sum9[7:0]))
		else $error("add immediate result wrong");

	add_flags_a: assert property (
		go_add |=> flags.carry == $past(chk_sum9[8])
			&& flags.half_carry == $past(chk_half)
			&& flags.zero == (wreg == 8'h00))
		else $error("add immediate flags wrong");

	andf_wreg_a: assert property (
		go_andf && !next_cmd.dest |=> wreg == $past(wreg & file_rd))
		else $error("and with file to working register wrong");

	andf_file_a: assert property (
		go_andf && next_cmd.dest |=> $stable(wreg)
			&& file_q[$past(next_cmd.file_addr)] == $past(wreg & file_rd))
		else $error("and with file write back wrong");

	file_range_a: assert property (
		do_write && wr_file && w_strb_q[0] |=>
			file_q[$past(wr_idx)] == $past(w_data_q[7:0]))
		else $error("file location not reached");

	andf_flags_a: assert property (
		go_andf |=> $stable(flags.carry) && $stable(flags.half_carry)
			&& flags.zero == ($past(wreg & file_rd) == 8'h00))
		else $error("and with file flags wrong");

	andi_result_a: assert property (
		go_andi |=> wreg == $past(wreg & next_cmd.imm))
		else $error("and immediate result wrong");

	andi_flags_a: assert property (
		go_andi |=> $stable(flags.carry) && $stable(flags.half_carry)
			&& flags.zero == (wreg == 8'h00))
		else $error("and immediate flags wrong");

	one_cycle_a: assert property (
		launch |=> s_axi_bvalid_o && !aw_full ##1 $stable(wreg) [*2])
		else $error("operation not done in one cycle");

	zero_def_a: assert property (
		(go_add || go_andi) ##1 flags.zero |-> wreg == 8'h00)
		else $error("zero flag set on nonzero result");

	add_carry_c: cover property (go_add && chk_sum9[8]);
	andf_file_c: cover property (go_andf && next_cmd.dest);
	andi_zero_c: cover property (go_andi ##1 flags.zero);

endmodule // aalo_top
